// ### rtl/keypad_pin_interrupt.sv
// Keypad pin interrupt unit with an AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite and the address map.
module keypad_pin_interrupt (
	// Clock and reset
	input  wire logic                               clk_i,
	input  wire logic                               arst_n_i,
	// AXI4-Lite write address
	input  wire logic [kbi_pkg::ADDR_W-1:0]         s_axi_awaddr_i,
	input  wire logic                               s_axi_awvalid_i,
	output logic                                    s_axi_awready_o,
	// AXI4-Lite write data
	input  wire logic [kbi_pkg::DATA_W-1:0]         s_axi_wdata_i,
	input  wire logic [kbi_pkg::DATA_W/8-1:0]       s_axi_wstrb_i,
	input  wire logic                               s_axi_wvalid_i,
	output logic                                    s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0]                              s_axi_bresp_o,
	output logic                                    s_axi_bvalid_o,
	input  wire logic                               s_axi_bready_i,
	// AXI4-Lite read address
	input  wire logic [kbi_pkg::ADDR_W-1:0]         s_axi_araddr_i,
	input  wire logic                               s_axi_arvalid_i,
	output logic                                    s_axi_arready_o,
	// AXI4-Lite read data
	output logic [kbi_pkg::DATA_W-1:0]              s_axi_rdata_o,
	output logic [1:0]                              s_axi_rresp_o,
	output logic                                    s_axi_rvalid_o,
	input  wire logic                               s_axi_rready_i,
	// Key pins and power mode
	input  wire logic [kbi_pkg::NUM_PINS-1:0]       key_pins_i,
	input  wire logic                               stop_mode_i,
	input  wire logic                               wait_mode_i,
	// Requests out
	output logic                                    key_irq_o,
	output logic                                    irq_o,
	output logic                                    wake_o
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Low two address bits are ignored: every register is one word
	function automatic kbi_pkg::reg_sel_e reg_index(input logic [kbi_pkg::ADDR_W-1:0] addr);
		logic [kbi_pkg::ADDR_W-1:0] word;
		word = {addr[kbi_pkg::ADDR_W-1:2], 2'b00};
		if (word == kbi_pkg::OFS_STATUS_CONTROL) begin
			return kbi_pkg::SEL_CTRL;
		end else if (word == kbi_pkg::OFS_PIN_ENABLE) begin
			return kbi_pkg::SEL_PINEN;
		end else if (word == kbi_pkg::OFS_EVENT_STATUS) begin
			return kbi_pkg::SEL_EVT;
		end else if (word == kbi_pkg::OFS_EVENT_MASK) begin
			return kbi_pkg::SEL_MASK;
		end else begin
			return kbi_pkg::SEL_NONE;
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		// Control and status
		logic [3:0]                     polarity;
		logic                           pending;
		logic                           irq_enable;
		logic                           detect_mode;
		logic [kbi_pkg::NUM_PINS-1:0]   pin_enable;
		logic [kbi_pkg::NUM_EVT-1:0]    evt_status;
		logic [kbi_pkg::NUM_EVT-1:0]    evt_mask;
		// Previous synchronised sample of every pin
		logic [kbi_pkg::NUM_PINS-1:0]   prev_pins;
		// Write channel holding
		logic                           aw_held;
		logic [kbi_pkg::ADDR_W-1:0]     aw_addr;
		logic                           w_held;
		logic [7:0]                     w_data;
		logic                           w_lane0;
		logic                           awready;
		logic                           wready;
		logic                           bvalid;
		logic [1:0]                     bresp;
		// Read channel
		logic                           arready;
		logic                           rvalid;
		logic [kbi_pkg::DATA_W-1:0]     rdata;
		logic [1:0]                     rresp;
		// Outputs
		logic                           key_irq;
		logic                           irq;
		logic                           wake;
	} state_s;

	state_s state_r;
	state_s state_nxt;

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	logic [kbi_pkg::NUM_PINS-1:0] pins_sync;

	key_sync u_key_sync (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.d_i      (key_pins_i),
		.q_o      (pins_sync)
	);

	// ----------------------------------------------------------------
	// Asserted levels per pin
	// ----------------------------------------------------------------
	logic [kbi_pkg::NUM_PINS-1:0] asserted_now;
	logic [kbi_pkg::NUM_PINS-1:0] asserted_prev;

	genvar gi;
	generate
		for (gi = 0; gi < kbi_pkg::NUM_PINS; gi++) begin : g_level
			if (gi < kbi_pkg::FIXED_PINS) begin : g_fixed
				// Low pins are active low only
				assign asserted_now[gi]  = ~pins_sync[gi];
				assign asserted_prev[gi] = ~state_r.prev_pins[gi];
			end else begin : g_sel
				// Polarity bit 1 turns a high level into the asserted one
				assign asserted_now[gi]  = pins_sync[gi] ~^
					state_r.polarity[gi-kbi_pkg::FIXED_PINS];
				assign asserted_prev[gi] = state_r.prev_pins[gi] ~^
					state_r.polarity[gi-kbi_pkg::FIXED_PINS];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Trigger detection
	// ----------------------------------------------------------------
	logic [kbi_pkg::NUM_PINS-1:0] en_now;
	logic [kbi_pkg::NUM_PINS-1:0] en_rise;
	logic                         edge_only_hit;
	logic                         edge_level_hit;
	logic                         level_hold;
	logic                         trigger;

	always_comb begin
		// Disabled pins are masked out before anything else looks at them
		en_now  = asserted_now & state_r.pin_enable;
		// Deasserted on one cycle, asserted on the next
		en_rise = en_now & ~asserted_prev;
		edge_only_hit = |en_rise;
		// A new edge only while no other enabled pin stays asserted from the cycle before
		edge_level_hit = (|en_rise) && !(|(en_now & ~en_rise & asserted_prev)) &&
			!(|(en_now & ~en_rise));
		level_hold = state_r.detect_mode && (|en_now);
		if (stop_mode_i) begin
			// Clocks would be gone in stop: level alone must count
			trigger = |en_now;
		end else if (state_r.detect_mode) begin
			trigger = edge_level_hit || level_hold;
		end else begin
			trigger = edge_only_hit;
		end
	end

	// ----------------------------------------------------------------
	// Bus handshakes
	// ----------------------------------------------------------------
	logic              aw_hs;
	logic              w_hs;
	logic              ar_hs;
	logic              do_write;
	kbi_pkg::reg_sel_e wsel;
	kbi_pkg::reg_sel_e rsel;
	logic [kbi_pkg::ADDR_W-1:0] waddr;
	logic [7:0]        wbyte;
	logic              wlane;

	always_comb begin
		aw_hs    = s_axi_awvalid_i && state_r.awready;
		w_hs     = s_axi_wvalid_i && state_r.wready;
		ar_hs    = s_axi_arvalid_i && state_r.arready;
		waddr    = state_r.aw_held ? state_r.aw_addr : s_axi_awaddr_i;
		wbyte    = state_r.w_held ? state_r.w_data : s_axi_wdata_i[7:0];
		wlane    = state_r.w_held ? state_r.w_lane0 : s_axi_wstrb_i[0];
		do_write = (state_r.aw_held || aw_hs) && (state_r.w_held || w_hs) &&
			!state_r.bvalid;
		wsel     = reg_index(waddr);
		rsel     = reg_index(s_axi_araddr_i);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic                        ack_write;
	logic                        evt_rd_clear;
	logic [kbi_pkg::NUM_EVT-1:0] evt_set;
	logic                        wake_level;

	always_comb begin
		state_nxt = state_r;

		// Sample history for edge comparison
		state_nxt.prev_pins = pins_sync;

		// Write channel capture, either order
		if (aw_hs) begin
			state_nxt.aw_held = 1'b1;
			state_nxt.aw_addr = s_axi_awaddr_i;
		end
		if (w_hs) begin
			state_nxt.w_held  = 1'b1;
			state_nxt.w_data  = s_axi_wdata_i[7:0];
			state_nxt.w_lane0 = s_axi_wstrb_i[0];
		end

		// Register writes; only byte lane 0 carries data
		ack_write = 1'b0;
		if (do_write) begin
			state_nxt.aw_held = 1'b0;
			state_nxt.w_held  = 1'b0;
			state_nxt.bvalid  = 1'b1;
			state_nxt.bresp   = kbi_pkg::RESP_OKAY;
			if (wsel == kbi_pkg::SEL_NONE) begin
				state_nxt.bresp = kbi_pkg::RESP_SLVERR;
			end else if (wlane) begin
				case (wsel)
					kbi_pkg::SEL_CTRL: begin
						state_nxt.polarity    = wbyte[7:kbi_pkg::POS_POLARITY_LO];
						state_nxt.irq_enable  = wbyte[kbi_pkg::POS_IRQ_ENABLE];
						state_nxt.detect_mode = wbyte[kbi_pkg::POS_DETECT_MODE];
						ack_write             = wbyte[kbi_pkg::POS_ACK];
					end
					kbi_pkg::SEL_PINEN: begin
						state_nxt.pin_enable = wbyte;
					end
					kbi_pkg::SEL_MASK: begin
						state_nxt.evt_mask = wbyte[kbi_pkg::NUM_EVT-1:0];
					end
					default: begin
						state_nxt.bresp = kbi_pkg::RESP_OKAY;
					end
				endcase
			end
		end
		if (state_r.bvalid && s_axi_bready_i) begin
			state_nxt.bvalid = 1'b0;
		end

		// Pending flag: a trigger in the acknowledge cycle wins
		state_nxt.pending = trigger || (state_r.pending && !ack_write);

		// Reads; a read of the event status clears it
		evt_rd_clear = 1'b0;
		if (ar_hs) begin
			state_nxt.rvalid = 1'b1;
			state_nxt.rresp  = kbi_pkg::RESP_OKAY;
			state_nxt.rdata  = '0;
			if (rsel == kbi_pkg::SEL_CTRL) begin
				state_nxt.rdata[7:kbi_pkg::POS_POLARITY_LO] = state_r.polarity;
				state_nxt.rdata[kbi_pkg::POS_PENDING]       = state_r.pending;
				state_nxt.rdata[kbi_pkg::POS_ACK]           = 1'b0;
				state_nxt.rdata[kbi_pkg::POS_IRQ_ENABLE]    = state_r.irq_enable;
				state_nxt.rdata[kbi_pkg::POS_DETECT_MODE]   = state_r.detect_mode;
			end else if (rsel == kbi_pkg::SEL_PINEN) begin
				state_nxt.rdata[kbi_pkg::NUM_PINS-1:0] = state_r.pin_enable;
			end else if (rsel == kbi_pkg::SEL_EVT) begin
				state_nxt.rdata[kbi_pkg::NUM_EVT-1:0] = state_r.evt_status;
				evt_rd_clear = 1'b1;
			end else if (rsel == kbi_pkg::SEL_MASK) begin
				state_nxt.rdata[kbi_pkg::NUM_EVT-1:0] = state_r.evt_mask;
			end else begin
				state_nxt.rresp = kbi_pkg::RESP_SLVERR;
			end
		end else if (state_r.rvalid && s_axi_rready_i) begin
			state_nxt.rvalid = 1'b0;
		end

		// Sticky events; a new event survives the clearing read
		wake_level = (stop_mode_i || wait_mode_i) && (|en_now);
		evt_set = '0;
		evt_set[kbi_pkg::POS_EVT_TRIGGER] = trigger && !state_r.pending;
		evt_set[kbi_pkg::POS_EVT_WAKE]    = wake_level;
		if (evt_rd_clear) begin
			state_nxt.evt_status = evt_set;
		end else begin
			state_nxt.evt_status = state_r.evt_status | evt_set;
		end

		// Ready flags are registered so that every output is a flop
		state_nxt.awready = !state_nxt.aw_held && !state_nxt.bvalid;
		state_nxt.wready  = !state_nxt.w_held && !state_nxt.bvalid;
		state_nxt.arready = !state_nxt.rvalid;

		// Requests out, one cycle behind their cause
		state_nxt.key_irq = state_nxt.pending && state_nxt.irq_enable;
		state_nxt.irq     = |(state_nxt.evt_status & state_nxt.evt_mask);
		state_nxt.wake    = wake_level;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r             <= '0;
			state_r.polarity    <= kbi_pkg::RST_POLARITY;
			state_r.pin_enable  <= kbi_pkg::RST_PIN_EN;
			state_r.evt_status  <= kbi_pkg::RST_EVT;
			state_r.evt_mask    <= kbi_pkg::RST_EVT;
			state_r.awready     <= 1'b1;
			state_r.wready      <= 1'b1;
			state_r.arready     <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_o = state_r.awready;
	assign s_axi_wready_o  = state_r.wready;
	assign s_axi_bvalid_o  = state_r.bvalid;
	assign s_axi_bresp_o   = state_r.bresp;
	assign s_axi_arready_o = state_r.arready;
	assign s_axi_rvalid_o  = state_r.rvalid;
	assign s_axi_rdata_o   = state_r.rdata;
	assign s_axi_rresp_o   = state_r.rresp;
	assign key_irq_o       = state_r.key_irq;
	assign irq_o           = state_r.irq;
	assign wake_o          = state_r.wake;

endmodule

// ### inc/kbi_pkg.sv
// Constants and types shared by the keypad pin interrupt design
package kbi_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int unsigned NUM_PINS   = 8;
	localparam int unsigned FIXED_PINS = 4;
	localparam int unsigned SYNC_DEPTH = 2;
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned NUM_EVT    = 2;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PIN_ENABLE     = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_EVENT_MASK     = 8'h0C;

	// ----------------------------------------------------------------
	// Field positions of key_status_control
	// ----------------------------------------------------------------
	localparam int unsigned POS_POLARITY_LO = 4;
	localparam int unsigned POS_PENDING     = 3;
	localparam int unsigned POS_ACK         = 2;
	localparam int unsigned POS_IRQ_ENABLE  = 1;
	localparam int unsigned POS_DETECT_MODE = 0;

	// Field positions of event status and mask
	localparam int unsigned POS_EVT_TRIGGER = 0;
	localparam int unsigned POS_EVT_WAKE    = 1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0]          RST_POLARITY = 4'h0;
	localparam logic [NUM_PINS-1:0] RST_PIN_EN   = 8'h00;
	localparam logic [NUM_EVT-1:0]  RST_EVT      = 2'h0;

	// ----------------------------------------------------------------
	// Bus answers and register selection
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SEL_CTRL  = 3'b000,
		SEL_PINEN = 3'b001,
		SEL_EVT   = 3'b010,
		SEL_MASK  = 3'b011,
		SEL_NONE  = 3'b100
	} reg_sel_e;

endpackage

// ### rtl/key_sync.sv
// Two-stage synchroniser for the key input pins
module key_sync (
	// Clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         arst_n_i,
	// Pins in, synchronised levels out
	input  wire logic [kbi_pkg::NUM_PINS-1:0] d_i,
	output logic      [kbi_pkg::NUM_PINS-1:0] q_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [kbi_pkg::NUM_PINS-1:0] meta;
		logic [kbi_pkg::NUM_PINS-1:0] sync;
	} sync_s;

	sync_s state_r;
	sync_s state_nxt;

	// First stage feeds only the second stage
	always_comb begin
		state_nxt      = state_r;
		state_nxt.meta = d_i;
		state_nxt.sync = state_r.meta;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign q_o = state_r.sync;

endmodule

// ### bench/key_bank.sv
// Key switch bank model driving the key pins
module key_bank (
	// Clock
	input  wire logic       clk_i,
	// Switch closure and asserted level per pin
	input  wire logic [7:0] press_i,
	input  wire logic [7:0] high_i,
	// Pin levels
	output logic      [7:0] pins_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Open switch leaves the pin at its idle level, the inverse of the asserted one
	always @(posedge clk_i) begin
		pins_o <= ~(press_i ^ high_i);
	end
endmodule

// ### bench/keypad_pin_interrupt_sva.sv
// Bus and wake checker bound to the keypad pin interrupt unit
module key_irq_checker (
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       arst_n_i,
	// Bus signals
	input  wire logic                       s_axi_awvalid_i,
	input  wire logic                       s_axi_awready_o,
	input  wire logic                       s_axi_wvalid_i,
	input  wire logic                       s_axi_wready_o,
	input  wire logic [1:0]                 s_axi_bresp_o,
	input  wire logic                       s_axi_bvalid_o,
	input  wire logic                       s_axi_bready_i,
	input  wire logic [kbi_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic                       s_axi_arvalid_i,
	input  wire logic                       s_axi_arready_o,
	input  wire logic [kbi_pkg::DATA_W-1:0] s_axi_rdata_o,
	input  wire logic [1:0]                 s_axi_rresp_o,
	input  wire logic                       s_axi_rvalid_o,
	input  wire logic                       s_axi_rready_i,
	// Power modes and wake
	input  wire logic                       stop_mode_i,
	input  wire logic                       wait_mode_i,
	input  wire logic                       wake_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	// Address of the read under way, so its answer can be judged
	logic [7:0] rd_addr_r;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_addr_r <= 8'h00;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rd_addr_r <= s_axi_araddr_i;
		end
	end
	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |=> s_axi_bvalid_o) else $error("Write answer late");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("Read answer late");
	a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
		&& $stable(s_axi_bresp_o)) else $error("Write answer dropped");
	a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
		&& $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o)) else $error("Read answer dropped");
	a_ready_low: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("Write taken during answer");
	a_read_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("Read taken during answer");
	a_upper_zero: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
		else $error("Upper read bits set");
	a_ack_reads_zero: assert property (
		s_axi_rvalid_o && rd_addr_r[7:2] == 6'h00 |-> !s_axi_rdata_o[2])
		else $error("Acknowledge bit read as one");
	a_unmapped_err: assert property (s_axi_rvalid_o && rd_addr_r[7:4] != 4'h0
		|-> s_axi_rresp_o == kbi_pkg::RESP_SLVERR && s_axi_rdata_o == 32'h00000000)
		else $error("Unmapped read not refused");
	a_wake_cause: assert property (wake_o |-> $past(stop_mode_i || wait_mode_i))
		else $error("Wake outside low power mode");
endmodule
bind keypad_pin_interrupt key_irq_checker key_irq_checker_inst (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .s_axi_awvalid_i(s_axi_awvalid_i),
	.s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
	.s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i), .stop_mode_i(stop_mode_i),
	.wait_mode_i(wait_mode_i), .wake_o(wake_o)
);

// ### bench/tb_top.sv
// Register level testbench for the keypad pin interrupt unit
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, arst_n_i, stop_m, wait_m, key_irq, irq, wake;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr, press, high, pins;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	int          err_count, comparisons;

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	keypad_pin_interrupt keypad_pin_interrupt_inst (
		.clk_i(clk_i), .arst_n_i(arst_n_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .key_pins_i(pins),
		.stop_mode_i(stop_m), .wait_mode_i(wait_m), .key_irq_o(key_irq),
		.irq_o(irq), .wake_o(wake)
	);
	key_bank key_bank_inst (.clk_i(clk_i), .press_i(press), .high_i(high), .pins_o(pins));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Waits are bounded by the watchdog, so a stuck handshake still ends the run
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		r = bresp;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask

	task automatic pend(input logic e);
		rd(8'h00);
		chk({31'h0, d[3]}, {31'h0, e});
	endtask

	// Enough edges for the bank flop, two sync stages, detection and the irq flop
	task automatic keys(input logic [7:0] p);
		@(posedge clk_i);
		press <= p;
		repeat (8) @(posedge clk_i);
	endtask

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		{arst_n_i, awvalid, wvalid, bready, arvalid, rready, stop_m, wait_m} = 8'h00;
		{awaddr, araddr, press, high} = 32'h0;
		wdata = 32'h0;
		wstrb = 4'hF;
		err_count = 0;
		comparisons = 0;
		repeat (5) @(posedge clk_i);
		arst_n_i <= 1'b1;
		for (int a = 0; a < 16; a += 4) begin
			rd(8'(a));
			chk(d, 32'h0);
		end
		keys(8'h01);
		pend(1'b0);
		keys(8'h00);
		wr(8'h0C, 32'h1);
		wr(8'h04, 32'h1);
		keys(8'h01);
		pend(1'b1);
		chk({31'h0, key_irq}, 32'h0);
		chk({31'h0, irq}, 32'h1);
		rd(8'h08);
		chk(d, 32'h1);
		rd(8'h08);
		chk(d, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(8'h00, 32'h2);
		repeat (3) @(posedge clk_i);
		chk({31'h0, key_irq}, 32'h1);
		wr(8'h00, 32'h6);
		rd(8'h00);
		chk(d, 32'h2);
		keys(8'h00);
		pend(1'b0);
		chk({31'h0, key_irq}, 32'h0);
		for (int n = 4; n < 8; n++) begin
			for (int p = 0; p < 2; p++) begin
				wr(8'h00, 32'(p << n));
				wr(8'h04, 32'(1 << n));
				@(posedge clk_i);
				high <= 8'(p << n);
				keys(8'h00);
				wr(8'h00, 32'(p << n) | 32'h4);
				keys(8'(1 << n));
				pend(1'b1);
				wr(8'h00, 32'(p << n) | 32'h4);
				keys(8'h00);
				pend(1'b0);
			end
		end
		wr(8'h00, 32'h0);
		@(posedge clk_i);
		high <= 8'h00;
		wr(8'h04, 32'h1);
		wr(8'h00, 32'h5);
		keys(8'h01);
		wr(8'h00, 32'h5);
		pend(1'b1);
		keys(8'h00);
		wr(8'h00, 32'h5);
		pend(1'b0);
		for (int m = 0; m < 2; m++) begin
			wr(8'h00, 32'h4);
			@(posedge clk_i);
			{wait_m, stop_m} <= m[0] ? 2'b10 : 2'b01;
			keys(8'h01);
			chk({31'h0, wake}, 32'h1);
			pend(1'b1);
			keys(8'h00);
			{wait_m, stop_m} <= 2'b00;
			repeat (3) @(posedge clk_i);
			chk({31'h0, wake}, 32'h0);
		end
		rd(8'h08);
		chk(d, 32'h3);
		wr(8'h10, 32'hFF);
		chk({30'h0, r}, {30'h0, kbi_pkg::RESP_SLVERR});
		rd(8'h10);
		chk({30'h0, r}, {30'h0, kbi_pkg::RESP_SLVERR});
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		give_verdict();
	end
endmodule
